// >>> srfc_defs.svh
// constants for the servo and rf control register bank
// assumes a 32-bit avalon-mm slave, byte addressed, one word per register
// Behaviour
// - word bits 15:12 name target register
// - reg0 bits 7:5 set summed input gain
// - reg0 bit 4 sets laser2 monitor level
// - reg0 bit 3 sets laser1 monitor level
// - reg0 bits 2,1 switch laser2, laser1
// - reg0 bit 0 powers up, zero standby
// - reg1 bit 11 picks phase offset source
// - reg1 bit 8 radial polarity, one normal
// - reg1 bit 5 enables dropout concealment
// - reg1 bit 4 two or four channel focus
// - reg1 bits 3:1 pick radial tracking method
// - reg1 bit 0 selects summed rf input
// - reg6 bits 11:8 radial output gain
// - reg6 bits 7:4 central output gain
// - reg12/13 hold central trims a to d
// - servo offset range scales central trims
// - reg2 bit 10 gates focus dac current
// - focus dac gate is active low
// - summed, source zero: right trim drives both
`ifndef SRFC_DEFS_SVH
`define SRFC_DEFS_SVH

// ************************************************************
// bus map
// ************************************************************
`define SRFC_ADDR_W 7
`define SRFC_NREGS 16
`define SRFC_IDX_CMD 5'h10
`define SRFC_IDX_STATUS 5'h11
`define SRFC_FULL_BE 2'h3

// ************************************************************
// control word layout
// ************************************************************
`define SRFC_SEL_HI 15
`define SRFC_SEL_LO 12
`define SRFC_DATA_HI 11

// ************************************************************
// register numbers
// ************************************************************
`define SRFC_R_POWER 4'h0
`define SRFC_R_MODE 4'h1
`define SRFC_R_FOCUS 4'h2
`define SRFC_R_RFGAIN 4'h3
`define SRFC_R_RFTRIM 4'h4
`define SRFC_R_SUMTRIM 4'h5
`define SRFC_R_OUTGAIN 4'h6
`define SRFC_R_RADTRIM 4'hB
`define SRFC_R_CTRIM_AB 4'hC
`define SRFC_R_CTRIM_CD 4'hD

// ************************************************************
// used bit masks and reset values
// ************************************************************
`define SRFC_MASK_POWER 12'h0FF
`define SRFC_MASK_MODE 12'h93F
`define SRFC_MASK_FOCUS 12'hFE0
`define SRFC_MASK_RFGAIN 12'hFF0
`define SRFC_MASK_ALL 12'hFFF
`define SRFC_RST_MODE 12'h100
`define SRFC_RST_OTHER 12'h000

// ************************************************************
// field positions
// ************************************************************
`define SRFC_B_POWER 0
`define SRFC_B_L1_ON 1
`define SRFC_B_L2_ON 2
`define SRFC_B_L1_LVL 3
`define SRFC_B_L2_LVL 4
`define SRFC_F_GAIN_HI 7
`define SRFC_F_GAIN_LO 5
`define SRFC_GAIN_MAX 3'h4
`define SRFC_B_SUMMED_INPUT_SELECT 0
`define SRFC_F_TRK_HI 3
`define SRFC_F_TRK_LO 1
`define SRFC_B_FOCUS4 4
`define SRFC_B_DOC 5
`define SRFC_B_RADPOL 8
`define SRFC_B_DACSRC 11
`define SRFC_B_FGATE 10
`define SRFC_B_SRVRANGE 11
`define SRFC_F_LEFT_HI 11
`define SRFC_F_LEFT_LO 6
`define SRFC_F_RIGHT_HI 5
`define SRFC_F_RIGHT_LO 0
`define SRFC_F_HIGH_HI 11
`define SRFC_F_HIGH_LO 8
`define SRFC_F_MID_HI 7
`define SRFC_F_MID_LO 4
`define SRFC_F_LOW_HI 3
`define SRFC_F_LOW_LO 0
`define SRFC_B_ST_RSVD 0

`endif

// >>> srfc_pkg.sv
// types for the servo and rf control register bank
// assumes srfc_defs.svh is compiled alongside
package srfc_pkg;

    typedef enum logic [2:0] {
        SRFC_TRK_PHASE_AD,
        SRFC_TRK_PUSHPULL_AD,
        SRFC_TRK_PHASE_SUM,
        SRFC_TRK_PUSHPULL_FOUR,
        SRFC_TRK_PHASE_FOUR,
        SRFC_TRK_THREE_BEAM,
        SRFC_TRK_RESERVED
    } srfc_track_t;

endpackage

// >>> srfc_regs.sv
// control register bank of the servo and rf front end
// assumes synchronous avalon-mm master on clock_i, one clock domain
//
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "srfc_defs.svh"

module srfc_regs (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic [`SRFC_ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    output logic power_up_o,
    output logic laser1_on_o,
    output logic laser2_on_o,
    output logic laser1_monitor_level_o,
    output logic laser2_monitor_level_o,
    output logic [2:0] summed_input_gain_o,
    output logic summed_input_select_o,
    output srfc_pkg::srfc_track_t radial_tracking_method_o,
    output logic focus_four_channel_o,
    output logic dropout_conceal_enable_o,
    output logic radial_polarity_o,
    output logic [5:0] phase_offset_dac_o,
    output logic [5:0] sum_offset_dac_o,
    output logic [3:0] radial_output_gain_o,
    output logic [3:0] central_output_gain_o,
    output logic [3:0] central_trim_a_o,
    output logic [3:0] central_trim_b_o,
    output logic [3:0] central_trim_c_o,
    output logic [3:0] central_trim_d_o,
    output logic servo_offset_range_o,
    output logic focus_dac_enable_o,
    output logic reserved_code_o
);
    import srfc_pkg::*;

    // ************************************************************
    // bus handshake
    // ************************************************************
    logic ack_q;
    logic req;
    logic wr_take;
    logic rd_load;
    logic [4:0] idx;
    logic cmd_ok;
    logic [3:0] target;
    logic [11:0] cmd_data;
    logic [11:0] reg_q [`SRFC_NREGS];
    logic rsvd_q;
    logic rsvd_hit;
    logic [31:0] rdata_d;

    assign req = avs_read_i | avs_write_i;
    assign avs_waitrequest_o = req & ~ack_q;
    assign wr_take = avs_write_i & ack_q;
    assign rd_load = avs_read_i & ~ack_q;
    assign idx = avs_address_i[`SRFC_ADDR_W-1:2];

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end

    // ************************************************************
    // control word decode
    // ************************************************************
    // only a full low half word counts as a control word
    assign cmd_ok = wr_take && idx == `SRFC_IDX_CMD &&
        avs_byteenable_i[1:0] == `SRFC_FULL_BE;
    assign target = avs_writedata_i[`SRFC_SEL_HI:`SRFC_SEL_LO];
    assign cmd_data = avs_writedata_i[`SRFC_DATA_HI:0];

    function automatic logic [11:0] used_mask(input logic [3:0] r);
        unique case (r)
            `SRFC_R_POWER: used_mask = `SRFC_MASK_POWER;
            `SRFC_R_MODE: used_mask = `SRFC_MASK_MODE;
            `SRFC_R_FOCUS: used_mask = `SRFC_MASK_FOCUS;
            `SRFC_R_RFGAIN: used_mask = `SRFC_MASK_RFGAIN;
            default: used_mask = `SRFC_MASK_ALL;
        endcase
    endfunction

    function automatic srfc_track_t track_decode(input logic [2:0] c);
        if (c[1:0] == 2'h3) begin
            track_decode = SRFC_TRK_THREE_BEAM;
        end else begin
            unique case (c)
                3'h0: track_decode = SRFC_TRK_PHASE_AD;
                3'h1: track_decode = SRFC_TRK_PUSHPULL_AD;
                3'h4: track_decode = SRFC_TRK_PHASE_SUM;
                3'h5: track_decode = SRFC_TRK_PUSHPULL_FOUR;
                3'h6: track_decode = SRFC_TRK_PHASE_FOUR;
                default: track_decode = SRFC_TRK_RESERVED;
            endcase
        end
    endfunction

    // ************************************************************
    // register storage
    // ************************************************************
    genvar g;
    generate
        for (g = 0; g < `SRFC_NREGS; g++) begin : g_reg
            always_ff @(posedge clock_i or posedge rst_i) begin
                if (rst_i) begin
                    reg_q[g] <= (4'(g) == `SRFC_R_MODE) ?
                        `SRFC_RST_MODE : `SRFC_RST_OTHER;
                end else if (cmd_ok && target == 4'(g)) begin
                    // unused bits stored as zero
                    reg_q[g] <= cmd_data & used_mask(4'(g));
                end
            end
        end
    endgenerate

    // ************************************************************
    // reserved code flag
    // ************************************************************
    assign rsvd_hit = cmd_ok && (
        (target == `SRFC_R_POWER &&
         cmd_data[`SRFC_F_GAIN_HI:`SRFC_F_GAIN_LO] > `SRFC_GAIN_MAX) ||
        (target == `SRFC_R_MODE &&
         track_decode(cmd_data[`SRFC_F_TRK_HI:`SRFC_F_TRK_LO]) ==
         SRFC_TRK_RESERVED));

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            rsvd_q <= 1'b0;
        end else if (rsvd_hit) begin
            rsvd_q <= 1'b1;
        end else if (wr_take && idx == `SRFC_IDX_STATUS &&
                     avs_byteenable_i[0] &&
                     avs_writedata_i[`SRFC_B_ST_RSVD]) begin
            rsvd_q <= 1'b0;
        end
    end

    // ************************************************************
    // read path
    // ************************************************************
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (idx < 5'(`SRFC_NREGS)) begin
            rdata_d = {16'h0000, idx[3:0], reg_q[idx[3:0]]};
        end else if (idx == `SRFC_IDX_STATUS) begin
            rdata_d[`SRFC_B_ST_RSVD] = rsvd_q;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            avs_readdata_o <= 32'h0000_0000;
        end else if (rd_load) begin
            avs_readdata_o <= rdata_d;
        end
    end

    // ************************************************************
    // field outputs
    // ************************************************************
    logic [11:0] r0;
    logic [11:0] r1;
    logic [11:0] r2;
    logic [11:0] r4;
    logic [11:0] r5;
    logic [11:0] r6;
    logic [11:0] r11;
    logic [11:0] r12;
    logic [11:0] r13;
    logic shared_trim;

    assign r0 = reg_q[`SRFC_R_POWER];
    assign r1 = reg_q[`SRFC_R_MODE];
    assign r2 = reg_q[`SRFC_R_FOCUS];
    assign r4 = reg_q[`SRFC_R_RFTRIM];
    assign r5 = reg_q[`SRFC_R_SUMTRIM];
    assign r6 = reg_q[`SRFC_R_OUTGAIN];
    assign r11 = reg_q[`SRFC_R_RADTRIM];
    assign r12 = reg_q[`SRFC_R_CTRIM_AB];
    assign r13 = reg_q[`SRFC_R_CTRIM_CD];
    assign shared_trim = r1[`SRFC_B_SUMMED_INPUT_SELECT] & ~r1[`SRFC_B_DACSRC];

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            power_up_o <= 1'b0;
            laser1_on_o <= 1'b0;
            laser2_on_o <= 1'b0;
            laser1_monitor_level_o <= 1'b0;
            laser2_monitor_level_o <= 1'b0;
            summed_input_gain_o <= 3'h0;
        end else begin
            power_up_o <= r0[`SRFC_B_POWER];
            laser1_on_o <= r0[`SRFC_B_L1_ON];
            laser2_on_o <= r0[`SRFC_B_L2_ON];
            laser1_monitor_level_o <= r0[`SRFC_B_L1_LVL];
            laser2_monitor_level_o <= r0[`SRFC_B_L2_LVL];
            summed_input_gain_o <=
                r0[`SRFC_F_GAIN_HI:`SRFC_F_GAIN_LO];
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            summed_input_select_o <= 1'b0;
            radial_tracking_method_o <= SRFC_TRK_PHASE_AD;
            focus_four_channel_o <= 1'b0;
            dropout_conceal_enable_o <= 1'b0;
            radial_polarity_o <= 1'b1;
            phase_offset_dac_o <= 6'h00;
            sum_offset_dac_o <= 6'h00;
        end else begin
            summed_input_select_o <= r1[`SRFC_B_SUMMED_INPUT_SELECT];
            radial_tracking_method_o <=
                track_decode(r1[`SRFC_F_TRK_HI:`SRFC_F_TRK_LO]);
            focus_four_channel_o <= r1[`SRFC_B_FOCUS4];
            dropout_conceal_enable_o <= r1[`SRFC_B_DOC];
            radial_polarity_o <= r1[`SRFC_B_RADPOL];
            if (shared_trim) begin
                // right trim drives both channels alike
                phase_offset_dac_o <=
                    r4[`SRFC_F_RIGHT_HI:`SRFC_F_RIGHT_LO];
                sum_offset_dac_o <=
                    r4[`SRFC_F_RIGHT_HI:`SRFC_F_RIGHT_LO];
            end else begin
                phase_offset_dac_o <= r1[`SRFC_B_DACSRC] ?
                    r5[`SRFC_F_RIGHT_HI:`SRFC_F_RIGHT_LO] :
                    r4[`SRFC_F_LEFT_HI:`SRFC_F_LEFT_LO];
                sum_offset_dac_o <= r5[`SRFC_F_RIGHT_HI:`SRFC_F_RIGHT_LO];
            end
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            radial_output_gain_o <= 4'h0;
            central_output_gain_o <= 4'h0;
            central_trim_a_o <= 4'h0;
            central_trim_b_o <= 4'h0;
            central_trim_c_o <= 4'h0;
            central_trim_d_o <= 4'h0;
            servo_offset_range_o <= 1'b0;
            focus_dac_enable_o <= 1'b1;
            reserved_code_o <= 1'b0;
        end else begin
            radial_output_gain_o <=
                r6[`SRFC_F_HIGH_HI:`SRFC_F_HIGH_LO];
            central_output_gain_o <=
                r6[`SRFC_F_MID_HI:`SRFC_F_MID_LO];
            central_trim_a_o <= r12[`SRFC_F_MID_HI:`SRFC_F_MID_LO];
            central_trim_b_o <= r12[`SRFC_F_LOW_HI:`SRFC_F_LOW_LO];
            central_trim_c_o <= r13[`SRFC_F_MID_HI:`SRFC_F_MID_LO];
            central_trim_d_o <= r13[`SRFC_F_LOW_HI:`SRFC_F_LOW_LO];
            servo_offset_range_o <= r11[`SRFC_B_SRVRANGE];
            // gate bit low means current on
            focus_dac_enable_o <= ~r2[`SRFC_B_FGATE];
            reserved_code_o <= rsvd_q;
        end
    end

endmodule

// >>> srfc_regs_assertions.sv
// checker on the ports of the control register bank
// assumes bound to srfc_regs, one clock, async high reset
`timescale 1ns/1ps
module srfc_regs_chk (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic [6:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire logic power_up_o,
    input wire logic laser1_on_o,
    input wire logic laser2_on_o,
    input wire logic laser1_monitor_level_o,
    input wire logic laser2_monitor_level_o,
    input wire logic [2:0] summed_input_gain_o,
    input wire srfc_pkg::srfc_track_t radial_tracking_method_o,
    input wire logic dropout_conceal_enable_o,
    input wire logic radial_polarity_o,
    input wire logic focus_dac_enable_o
);
    import srfc_pkg::*;
    // ****************************************
    // helpers
    // ****************************************
    logic done, full, w0, w1, w2;
    logic [3:0] sel;
    assign sel = avs_writedata_i[15:12];
    assign done = avs_write_i && !avs_waitrequest_o && avs_address_i == 7'h40;
    assign full = avs_byteenable_i[1:0] == 2'h3;
    assign w0 = done && full && sel == 4'h0;
    assign w1 = done && full && sel == 4'h1;
    assign w2 = done && full && sel == 4'h2;
    function automatic srfc_track_t trk(input logic [2:0] c);
        if (c[1:0] == 2'h3) return SRFC_TRK_THREE_BEAM;
        case (c)
            3'h0: return SRFC_TRK_PHASE_AD;
            3'h1: return SRFC_TRK_PUSHPULL_AD;
            3'h4: return SRFC_TRK_PHASE_SUM;
            3'h5: return SRFC_TRK_PUSHPULL_FOUR;
            3'h6: return SRFC_TRK_PHASE_FOUR;
            default: return SRFC_TRK_RESERVED;
        endcase
    endfunction
    // ****************************************
    // properties
    // ****************************************
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    property p_wait;
        (avs_read_i || avs_write_i) && avs_waitrequest_o
            |=> !avs_waitrequest_o;
    endproperty
    a_wait: assert property (p_wait)
        else $error("more than one wait cycle");
    property p_rdsel;
        avs_read_i && !avs_waitrequest_o && avs_address_i[6:3] == 4'h0
            |-> avs_readdata_o[15:12] == {2'h0, avs_address_i[3:2]};
    endproperty
    a_rdsel: assert property (p_rdsel)
        else $error("readback register number wrong");
    property p_power;
        w0 |-> ##2 power_up_o == $past(avs_writedata_i[0], 2);
    endproperty
    a_power: assert property (p_power)
        else $error("power bit not applied");
    property p_lasers;
        w0 |-> ##2 {laser2_on_o, laser1_on_o}
            == $past(avs_writedata_i[2:1], 2);
    endproperty
    a_lasers: assert property (p_lasers)
        else $error("laser switches not applied");
    property p_levels;
        w0 |-> ##2 {laser2_monitor_level_o, laser1_monitor_level_o}
            == $past(avs_writedata_i[4:3], 2);
    endproperty
    a_levels: assert property (p_levels)
        else $error("monitor levels not applied");
    property p_gain;
        w0 |-> ##2 summed_input_gain_o == $past(avs_writedata_i[7:5], 2);
    endproperty
    a_gain: assert property (p_gain)
        else $error("summed gain not applied");
    property p_mode;
        w1 |-> ##2 {radial_polarity_o, dropout_conceal_enable_o}
            == {$past(avs_writedata_i[8], 2), $past(avs_writedata_i[5], 2)};
    endproperty
    a_mode: assert property (p_mode)
        else $error("polarity or concealment wrong");
    property p_trk;
        w1 |-> ##2 radial_tracking_method_o
            == trk($past(avs_writedata_i[3:1], 2));
    endproperty
    a_trk: assert property (p_trk)
        else $error("tracking method wrong");
    property p_fgate;
        w2 |-> ##2 focus_dac_enable_o == !$past(avs_writedata_i[10], 2);
    endproperty
    a_fgate: assert property (p_fgate)
        else $error("focus dac gate wrong");
    property p_partial;
        done && !full |-> ##2 $stable(power_up_o)
            && $stable(summed_input_gain_o);
    endproperty
    a_partial: assert property (p_partial)
        else $error("partial word changed outputs");
endmodule

bind srfc_regs srfc_regs_chk u_chk (.clock_i(clock_i), .rst_i(rst_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .power_up_o(power_up_o),
    .laser1_on_o(laser1_on_o), .laser2_on_o(laser2_on_o),
    .laser1_monitor_level_o(laser1_monitor_level_o),
    .laser2_monitor_level_o(laser2_monitor_level_o),
    .summed_input_gain_o(summed_input_gain_o),
    .radial_tracking_method_o(radial_tracking_method_o),
    .dropout_conceal_enable_o(dropout_conceal_enable_o),
    .radial_polarity_o(radial_polarity_o),
    .focus_dac_enable_o(focus_dac_enable_o));

// >>> srfc_host.sv
// avalon-mm host model that sends control words and reads back
// assumes one clock; waits bounded, hang_o marks a timeout
`timescale 1ns/1ps
module srfc_host (
    input wire logic clock_i,
    input wire logic waitrequest_i,
    input wire logic [31:0] readdata_i,
    output logic [6:0] address_o,
    output logic read_o,
    output logic write_o,
    output logic [31:0] writedata_o,
    output logic [3:0] byteenable_o,
    output logic hang_o
);
    initial begin
        {address_o, read_o, write_o, writedata_o, byteenable_o} = '0;
        hang_o = 1'b0;
    end
    // one transfer, held until waitrequest seen low at an edge
    task automatic xfer(input logic r, input logic [6:0] a,
        input logic [31:0] d, input logic [3:0] b, output logic [31:0] q);
        logic w;
        int n;
        @(posedge clock_i);
        read_o <= r;
        write_o <= !r;
        address_o <= a;
        writedata_o <= d;
        byteenable_o <= b;
        w = 1'b1;
        n = 0;
        while (w && n < 20) begin
            @(posedge clock_i);
            w = waitrequest_i;
            q = readdata_i;
            n++;
        end
        if (w) hang_o <= 1'b1;
        read_o <= 1'b0;
        write_o <= 1'b0;
    endtask
    // 16-bit word with low byte enables be, register number on top, then field settle
    task automatic cw(input logic [15:0] w, input logic [1:0] be);
        logic [31:0] q;
        xfer(1'b0, 7'h40, {16'hA5A5, w}, {2'h3, be}, q);
        repeat (2) @(negedge clock_i);
    endtask
endmodule

// >>> srfc_tb.sv
// self-checking bench for the control register bank
// assumes srfc_host drives the bus, clock 200 MHz
`timescale 1ns/1ps
module testbench;
    import srfc_pkg::*;
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fails++; \
    $display("[ERR] %s exp %0h got %0h", n, e, g); end end
    logic clock_i, rst_i, rd, wr, wq, hang, pw, l1, l2, v1, v2;
    logic sel, f4, doc, pol, rng, fen, rsv;
    logic [6:0] adr;
    logic [31:0] wd, q, rdat;
    logic [3:0] be, rg, cg, ta, tb, tc, td;
    logic [2:0] gn;
    logic [5:0] pd, sd;
    srfc_track_t tm;
    int fails = 0, tests_run = 0;
    srfc_track_t tx[8] = '{SRFC_TRK_PHASE_AD, SRFC_TRK_PUSHPULL_AD,
        SRFC_TRK_RESERVED, SRFC_TRK_THREE_BEAM, SRFC_TRK_PHASE_SUM,
        SRFC_TRK_PUSHPULL_FOUR, SRFC_TRK_PHASE_FOUR, SRFC_TRK_THREE_BEAM};
    logic [4:0] lo;
    logic [11:0] m;
    srfc_host h (.clock_i(clock_i), .waitrequest_i(wq), .readdata_i(rdat),
        .address_o(adr), .read_o(rd), .write_o(wr), .writedata_o(wd),
        .byteenable_o(be), .hang_o(hang));
    srfc_regs dut (.clock_i(clock_i), .rst_i(rst_i), .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
        .avs_byteenable_i(be), .avs_readdata_o(rdat),
        .avs_waitrequest_o(wq), .power_up_o(pw), .laser1_on_o(l1),
        .laser2_on_o(l2), .laser1_monitor_level_o(v1),
        .laser2_monitor_level_o(v2), .summed_input_gain_o(gn),
        .summed_input_select_o(sel), .radial_tracking_method_o(tm),
        .focus_four_channel_o(f4), .dropout_conceal_enable_o(doc),
        .radial_polarity_o(pol), .phase_offset_dac_o(pd),
        .sum_offset_dac_o(sd), .radial_output_gain_o(rg),
        .central_output_gain_o(cg), .central_trim_a_o(ta),
        .central_trim_b_o(tb), .central_trim_c_o(tc),
        .central_trim_d_o(td), .servo_offset_range_o(rng),
        .focus_dac_enable_o(fen), .reserved_code_o(rsv));
    initial begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end
    task automatic end_sim;
        if (fails == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge hang) begin
        fails++;
        end_sim;
    end
    initial begin
        rst_i = 1'b1;
        repeat (16) @(posedge clock_i);
        rst_i <= 1'b0;
        @(negedge clock_i);
        `CHK("pol_rst", 1'b1, pol)
        `CHK("fen_rst", 1'b1, fen)
        `CHK("pwr_rst", 1'b0, pw)
        h.xfer(1'b1, 7'h04, 32'h0, 4'hF, q);
        `CHK("reg1_rst", 32'h0000_1100, q)
        // ****************************************
        // register 0 fields, gain codes 0 to 4
        // ****************************************
        for (int i = 0; i < 5; i++) begin
            lo = 5'(5'h0A + i * 7);
            h.cw({4'h0, 4'hF, 3'(i), lo}, 2'h3);
            `CHK("gain", 3'(i), gn)
            `CHK("lvl2", lo[4], v2)
            `CHK("lvl1", lo[3], v1)
            `CHK("lsr", lo[2:1], {l2, l1})
            `CHK("pwr", lo[0], pw)
            h.xfer(1'b1, 7'h00, 32'h0, 4'hF, q);
            `CHK("rb0", {24'h0, 3'(i), lo}, q)
        end
        h.cw(16'h00FF, 2'h1);
        h.cw(16'h00FF, 2'h2);
        h.xfer(1'b1, 7'h00, 32'h0, 4'hF, q);
        `CHK("partial", 32'h0000_0086, q)
        h.xfer(1'b1, 7'h44, 32'h0, 4'hF, q);
        `CHK("rsv_clr", 1'b0, q[0])
        // ****************************************
        // register 1 modes, every tracking code
        // ****************************************
        for (int t = 0; t < 8; t++) begin
            m = {t[0], 2'h3, t[1], 2'h3, t[2], ~t[0], 3'(t), t[1]};
            h.cw({4'h1, m}, 2'h3);
            `CHK("trk", tx[t], tm)
            `CHK("pol", t[1], pol)
            `CHK("doc", t[2], doc)
            `CHK("foc4", ~t[0], f4)
            `CHK("rfsel", t[1], sel)
            h.xfer(1'b1, 7'h04, 32'h0, 4'hF, q);
            `CHK("rb1", {20'h1, m & 12'h93F}, q)
        end
        h.xfer(1'b1, 7'h44, 32'h0, 4'hF, q);
        `CHK("rsv_set", 1'b1, q[0])
        `CHK("rsv_out", 1'b1, rsv)
        h.xfer(1'b0, 7'h44, 32'h1, 4'hF, q);
        h.xfer(1'b1, 7'h44, 32'h0, 4'hF, q);
        `CHK("rsv_cl2", 1'b0, q[0])
        h.xfer(1'b1, 7'h48, 32'h0, 4'hF, q);
        `CHK("unmapped", 32'h0, q)
        h.cw(16'h00A0, 2'h3);
        `CHK("gain_rsv", 3'h5, gn)
        h.xfer(1'b1, 7'h44, 32'h0, 4'hF, q);
        `CHK("rsv_gain", 1'b1, q[0])
        // ****************************************
        // offset dac routing
        // ****************************************
        h.cw(16'h4FC5, 2'h3);
        h.cw(16'h502A, 2'h3);
        for (int s = 0; s < 4; s++) begin
            h.cw({4'h1, s[1], 3'h1, 7'h0, s[0]}, 2'h3);
            `CHK("pdac", s == 1 ? 6'h05 : s[1] ? 6'h2A : 6'h3F, pd)
            `CHK("sdac", s == 1 ? 6'h05 : 6'h2A, sd)
        end
        // ****************************************
        // gains, trims, range, focus gate
        // ****************************************
        h.cw(16'h6A50, 2'h3);
        `CHK("rgain", 4'hA, rg)
        `CHK("cgain", 4'h5, cg)
        h.cw(16'hC39B, 2'h3);
        h.cw(16'hD3C4, 2'h3);
        `CHK("trims", 16'h9BC4, {ta, tb, tc, td})
        h.cw(16'hB800, 2'h3);
        `CHK("range", 1'b1, rng)
        h.cw(16'h2400, 2'h3);
        `CHK("fgate1", 1'b0, fen)
        h.cw(16'h2000, 2'h3);
        `CHK("fgate0", 1'b1, fen)
        end_sim;
    end
endmodule
